// file: hw/csar_status_bank.sv
// Purpose: charger phase status and three converter result registers on the byte register port
// Assumes: register port requests are single-cycle strobes from the serial engine
// Notes: every address in this bank is read-only; writes are acknowledged and dropped
`timescale 1ns/1ps
`include "csar_cfg.svh"

// Operation
// - status bits 7-5 carry the phase code
// - trickle below short level, pre-charge below minimum
// - bit 4 sticky timer expiry, soft reset clears
// - bit 3 mirrors thermal regulation, soft reset clears
// - bits 2-0 hold the strap code
// - strap bit 2 low means dual phase
// - battery result high byte at upper address
// - battery result clamped low, never negative
// - system power high byte at upper address
// - system power saturates at 1FFFh, soft reset clears
// - comparator result high byte at upper address
// - comparator result saturates at 1FFFh
module csar_status_bank (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire csar_pkg::csar_reg_req_t reg_req_i,
  output csar_pkg::csar_reg_rsp_t reg_rsp_o,
  input wire logic soft_reset_i,
  input wire logic charge_enable_i,
  input wire logic cv_mode_i,
  input wire logic term_done_i,
  input wire logic timer_expire_i,
  input wire logic thermal_regulation_i,
  input wire logic [2:0] strap_i,
  input wire logic [15:0] batt_short_mv_i,
  input wire logic [15:0] sys_min_mv_i,
  input wire csar_pkg::csar_sample_t batt_sample_i,
  input wire csar_pkg::csar_sample_t system_power_monitor_i,
  input wire csar_pkg::csar_sample_t cmp_sample_i,
  output csar_pkg::csar_status_t status_o,
  output logic [15:0] battery_voltage_o,
  output logic [15:0] system_power_result_o,
  output logic [15:0] comparator_input_result_o,
  output logic fsw_800k_o,
  output logic slow_comp_o,
  output logic dual_phase_o
);

  typedef struct packed {
    csar_pkg::csar_phase_t phase;
    logic timer_expired;
    logic thermal_active;
    logic ack;
    logic [7:0] rdata;
  } csar_bank_state_t;

  csar_bank_state_t state_ff;
  csar_bank_state_t nxt_state;
  logic [15:0] batt_res;
  logic [15:0] sys_res;
  logic [15:0] cmp_res;
  logic [2:0] strap_code;
  logic strap_captured;
  logic [7:0] status_byte;
  logic [7:0] rd_byte;

  // ==================================================================
  // byte selection shared by the three result registers
  function automatic logic [7:0] csar_pick_byte(input logic [15:0] word, input logic hi);
    logic [7:0] sel;
    sel = hi ? word[15:8] : word[7:0];
    return sel;
  endfunction : csar_pick_byte

  // ==================================================================
  // result holders
  csar_adc_cond #(
    .CLAMP_LOW(1'b1),
    .LIMIT(`CSAR_BATT_MAX),
    .SOFT_CLR(1'b0)
  ) u_batt (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .sample_i(batt_sample_i),
    .soft_reset_i(soft_reset_i),
    .result_o(batt_res)
  );

  csar_adc_cond #(
    .CLAMP_LOW(1'b0),
    .LIMIT(`CSAR_SYS_MAX),
    .SOFT_CLR(1'b1)
  ) u_sys (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .sample_i(system_power_monitor_i),
    .soft_reset_i(soft_reset_i),
    .result_o(sys_res)
  );

  csar_adc_cond #(
    .CLAMP_LOW(1'b0),
    .LIMIT(`CSAR_CMP_MAX),
    .SOFT_CLR(1'b0)
  ) u_cmp (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .sample_i(cmp_sample_i),
    .soft_reset_i(soft_reset_i),
    .result_o(cmp_res)
  );

  csar_strap_latch u_strap (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .strap_i(strap_i),
    .code_o(strap_code),
    .captured_o(strap_captured),
    .fsw_800k_o(fsw_800k_o),
    .slow_comp_o(slow_comp_o),
    .dual_phase_o(dual_phase_o)
  );

  // ==================================================================
  // status byte assembly
  always_comb
  begin
    status_byte = `CSAR_STATUS_RST;
    status_byte[`CSAR_PHASE_MSB:`CSAR_PHASE_LSB] = state_ff.phase;
    status_byte[`CSAR_TIMER_BIT] = state_ff.timer_expired;
    status_byte[`CSAR_THERM_BIT] = state_ff.thermal_active;
    status_byte[`CSAR_STRAP_MSB:`CSAR_STRAP_LSB] = strap_code;
  end

  // ==================================================================
  // read decode
  always_comb
  begin
    rd_byte = `CSAR_UNMAPPED_RD;
    unique case (reg_req_i.addr)
      `CSAR_OFS_STATUS: rd_byte = status_byte;
      `CSAR_OFS_BATT_LO: rd_byte = csar_pick_byte(batt_res, 1'b0);
      `CSAR_OFS_BATT_HI: rd_byte = csar_pick_byte(batt_res, 1'b1);
      `CSAR_OFS_SYS_LO: rd_byte = csar_pick_byte(sys_res, 1'b0);
      `CSAR_OFS_SYS_HI: rd_byte = csar_pick_byte(sys_res, 1'b1);
      `CSAR_OFS_CMP_LO: rd_byte = csar_pick_byte(cmp_res, 1'b0);
      `CSAR_OFS_CMP_HI: rd_byte = csar_pick_byte(cmp_res, 1'b1);
      default: rd_byte = `CSAR_UNMAPPED_RD;
    endcase
  end

  // ==================================================================
  // next state
  always_comb
  begin
    nxt_state = state_ff;
    // phase follows charger inputs and the held battery result
    if (!charge_enable_i)
    begin
      nxt_state.phase = csar_pkg::CSAR_PH_IDLE;
    end
    else if (term_done_i)
    begin
      nxt_state.phase = csar_pkg::CSAR_PH_DONE;
    end
    else if (batt_res < batt_short_mv_i)
    begin
      nxt_state.phase = csar_pkg::CSAR_PH_TRICKLE;
    end
    else if (batt_res < sys_min_mv_i)
    begin
      nxt_state.phase = csar_pkg::CSAR_PH_PRE;
    end
    else if (cv_mode_i)
    begin
      nxt_state.phase = csar_pkg::CSAR_PH_CV;
    end
    else
    begin
      nxt_state.phase = csar_pkg::CSAR_PH_CC;
    end
    // expiry event wins over a soft clear in the same cycle
    nxt_state.timer_expired = timer_expire_i
                              | (state_ff.timer_expired & ~soft_reset_i);
    nxt_state.thermal_active = thermal_regulation_i & ~soft_reset_i;
    // register port answer, writes change nothing
    nxt_state.ack = reg_req_i.rd | reg_req_i.wr;
    if (reg_req_i.rd)
    begin
      nxt_state.rdata = rd_byte;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_ff <= '{
        phase: csar_pkg::CSAR_PH_IDLE,
        timer_expired: 1'b0,
        thermal_active: 1'b0,
        ack: 1'b0,
        rdata: `CSAR_STATUS_RST
      };
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ==================================================================
  // outputs
  assign reg_rsp_o.ack = state_ff.ack;
  assign reg_rsp_o.rdata = state_ff.rdata;
  assign status_o.charge_phase_code = state_ff.phase;
  assign status_o.safety_timer_expired = state_ff.timer_expired;
  assign status_o.thermal_regulation_active = state_ff.thermal_active;
  assign status_o.strap_code = strap_code;
  assign battery_voltage_o = batt_res;
  assign system_power_result_o = sys_res;
  assign comparator_input_result_o = cmp_res;

  // ==================================================================
  // checks
  logic [7:0] batt_hi;
  logic [7:0] sys_lo;
  logic [7:0] cmp_hi;
  logic [15:0] batt_snap;
  logic [15:0] sys_snap;
  logic [15:0] cmp_snap;
  logic [7:0] status_snap;
  assign batt_hi = batt_res[15:8];
  assign sys_lo = sys_res[7:0];
  assign cmp_hi = cmp_res[15:8];

  default clocking csar_cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);

  a_phase_legal: assert property (
    (status_o.charge_phase_code != csar_pkg::CSAR_PH_RSV1)
    && (status_o.charge_phase_code != csar_pkg::CSAR_PH_RSV2))
    else $error("reserved phase code reported");

  a_phase_trickle: assert property (
    charge_enable_i && !term_done_i && (batt_res < batt_short_mv_i)
    |=> status_o.charge_phase_code == csar_pkg::CSAR_PH_TRICKLE)
    else $error("trickle phase not reported");

  a_phase_precharge: assert property (
    charge_enable_i && !term_done_i && (batt_res >= batt_short_mv_i)
    && (batt_res < sys_min_mv_i)
    |=> status_o.charge_phase_code == csar_pkg::CSAR_PH_PRE)
    else $error("pre-charge phase not reported");

  a_timer_sticky: assert property (
    timer_expire_i || (status_o.safety_timer_expired && !soft_reset_i)
    |=> status_o.safety_timer_expired)
    else $error("timer expiry flag did not hold");

  a_timer_clear: assert property (
    soft_reset_i && !timer_expire_i |=> !status_o.safety_timer_expired)
    else $error("soft reset did not clear timer flag");

  a_therm_follow: assert property (
    ##1 status_o.thermal_regulation_active
      == ($past(thermal_regulation_i) && !$past(soft_reset_i)))
    else $error("thermal status does not follow its input");

  a_strap_hold: assert property (
    strap_captured && $past(strap_captured) |-> $stable(strap_code))
    else $error("strap code changed after capture");

  a_dual_phase: assert property (
    strap_captured |-> dual_phase_o == !strap_code[2])
    else $error("dual phase flag disagrees with strap");

  a_batt_order: assert property (
    reg_req_i.rd && reg_req_i.addr == `CSAR_OFS_BATT_HI
    |=> reg_rsp_o.ack && reg_rsp_o.rdata == $past(batt_hi))
    else $error("battery high byte misplaced");

  a_batt_nonneg: assert property (
    batt_sample_i.valid && batt_sample_i.data[15] |=> batt_res == `CSAR_RESULT_RST)
    else $error("negative battery reading not clamped");

  a_sys_order: assert property (
    reg_req_i.rd && reg_req_i.addr == `CSAR_OFS_SYS_LO
    |=> reg_rsp_o.rdata == $past(sys_lo))
    else $error("system power low byte misplaced");

  a_sys_sat: assert property (
    system_power_monitor_i.valid && system_power_monitor_i.data > `CSAR_SYS_MAX
    |=> sys_res == `CSAR_SYS_MAX)
    else $error("system power not saturated");

  a_sys_clear: assert property (
    soft_reset_i && !system_power_monitor_i.valid |=> sys_res == `CSAR_RESULT_RST)
    else $error("soft reset did not clear system power");

  a_cmp_order: assert property (
    reg_req_i.rd && reg_req_i.addr == `CSAR_OFS_CMP_HI
    |=> reg_rsp_o.rdata == $past(cmp_hi))
    else $error("comparator high byte misplaced");

  a_cmp_sat: assert property (
    cmp_res <= `CSAR_CMP_MAX)
    else $error("comparator result above limit");

  // snapshot of stored values for the write check
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      batt_snap <= `CSAR_RESULT_RST;
      sys_snap <= `CSAR_RESULT_RST;
      cmp_snap <= `CSAR_RESULT_RST;
      status_snap <= `CSAR_STATUS_RST;
    end
    else
    begin
      batt_snap <= batt_res;
      sys_snap <= sys_res;
      cmp_snap <= cmp_res;
      status_snap <= status_byte;
    end
  end

  a_write_ignored: assert property (
    reg_req_i.wr && !reg_req_i.rd && !batt_sample_i.valid
    && !system_power_monitor_i.valid && !cmp_sample_i.valid && !soft_reset_i
    |=> reg_rsp_o.ack && batt_res == batt_snap && sys_res == sys_snap
      && cmp_res == cmp_snap)
    else $error("write altered a stored result");

  c_trickle: cover property (
    status_o.charge_phase_code == csar_pkg::CSAR_PH_TRICKLE);

  c_timer_then_clear: cover property (
    status_o.safety_timer_expired ##1 soft_reset_i ##1 !status_o.safety_timer_expired);

  c_hi_read: cover property (
    reg_req_i.rd && reg_req_i.addr == `CSAR_OFS_BATT_HI ##1 reg_rsp_o.ack);

  c_write: cover property (
    reg_req_i.wr && reg_req_i.addr == `CSAR_OFS_STATUS ##1 status_byte == status_snap);

endmodule : csar_status_bank

// file: hw/csar_cfg.svh
// Purpose: offsets, field positions, reset values and limits of the status and result bank
// Assumes: byte-wide register port, offsets are byte addresses
// Notes: definitions only
`ifndef CSAR_CFG_SVH
`define CSAR_CFG_SVH

// ==================================================================
// register offsets
`define CSAR_OFS_STATUS 8'h19
`define CSAR_OFS_BATT_LO 8'h1a
`define CSAR_OFS_BATT_HI 8'h1b
`define CSAR_OFS_SYS_LO 8'h1c
`define CSAR_OFS_SYS_HI 8'h1d
`define CSAR_OFS_CMP_LO 8'h1e
`define CSAR_OFS_CMP_HI 8'h1f

// ==================================================================
// status field positions
`define CSAR_PHASE_MSB 7
`define CSAR_PHASE_LSB 5
`define CSAR_TIMER_BIT 4
`define CSAR_THERM_BIT 3
`define CSAR_STRAP_MSB 2
`define CSAR_STRAP_LSB 0

// ==================================================================
// reset values and limits
`define CSAR_STATUS_RST 8'h00
`define CSAR_RESULT_RST 16'h0000
`define CSAR_UNMAPPED_RD 8'h00
`define CSAR_BATT_MAX 16'h7fff
`define CSAR_SYS_MAX 16'h1fff
`define CSAR_CMP_MAX 16'h1fff

`endif

// file: hw/csar_pkg.sv
// Purpose: shared types of the status and result bank
// Assumes: nothing
// Notes: constants live in csar_cfg.svh
package csar_pkg;

  // ==================================================================
  // charge phase codes
  typedef enum logic [2:0] {
    CSAR_PH_IDLE = 3'h0,
    CSAR_PH_TRICKLE = 3'h1,
    CSAR_PH_PRE = 3'h2,
    CSAR_PH_CC = 3'h3,
    CSAR_PH_CV = 3'h4,
    CSAR_PH_RSV1 = 3'h5,
    CSAR_PH_RSV2 = 3'h6,
    CSAR_PH_DONE = 3'h7
  } csar_phase_t;

  // ==================================================================
  // carriers
  typedef struct packed {
    csar_phase_t charge_phase_code;
    logic safety_timer_expired;
    logic thermal_regulation_active;
    logic [2:0] strap_code;
  } csar_status_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } csar_sample_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csar_reg_req_t;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } csar_reg_rsp_t;

endpackage : csar_pkg

// file: hw/csar_adc_cond.sv
// Purpose: holds one converter result, clamped low or saturated high
// Assumes: sample data is a raw 16-bit reading, valid for one cycle
// Notes: a new sample wins over a soft clear in the same cycle
`timescale 1ns/1ps
`include "csar_cfg.svh"

module csar_adc_cond #(
  parameter logic CLAMP_LOW = 1'b0,
  parameter logic [15:0] LIMIT = `CSAR_CMP_MAX,
  parameter logic SOFT_CLR = 1'b0
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire csar_pkg::csar_sample_t sample_i,
  input wire logic soft_reset_i,
  output logic [15:0] result_o
);

  typedef struct packed {
    logic [15:0] result;
  } csar_cond_state_t;

  csar_cond_state_t state_ff;
  csar_cond_state_t nxt_state;

  // ==================================================================
  // conditioning
  always_comb
  begin
    nxt_state = state_ff;
    if (sample_i.valid)
    begin
      if (CLAMP_LOW && sample_i.data[15])
      begin
        nxt_state.result = `CSAR_RESULT_RST;
      end
      else if (sample_i.data > LIMIT)
      begin
        nxt_state.result = LIMIT;
      end
      else
      begin
        nxt_state.result = sample_i.data;
      end
    end
    else if (SOFT_CLR && soft_reset_i)
    begin
      nxt_state.result = `CSAR_RESULT_RST;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_ff <= '{result: `CSAR_RESULT_RST};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign result_o = state_ff.result;

endmodule : csar_adc_cond

// file: hw/csar_strap_latch.sv
// Purpose: catches the mode strap once after reset release and decodes it
// Assumes: strap pin is settled when reset is released
// Notes: the code never changes again until the next hard reset
`timescale 1ns/1ps

module csar_strap_latch (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [2:0] strap_i,
  output logic [2:0] code_o,
  output logic captured_o,
  output logic fsw_800k_o,
  output logic slow_comp_o,
  output logic dual_phase_o
);

  typedef struct packed {
    logic captured;
    logic dual_phase;
    logic [2:0] code;
  } csar_strap_state_t;

  csar_strap_state_t state_ff;
  csar_strap_state_t nxt_state;

  // ==================================================================
  // capture at the first edge after release
  always_comb
  begin
    nxt_state = state_ff;
    if (!state_ff.captured)
    begin
      nxt_state.captured = 1'b1;
      nxt_state.code = strap_i;
      nxt_state.dual_phase = ~strap_i[2];
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_ff <= '{captured: 1'b0, dual_phase: 1'b0, code: 3'h0};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign code_o = state_ff.code;
  assign captured_o = state_ff.captured;
  assign fsw_800k_o = state_ff.code[0];
  assign slow_comp_o = state_ff.code[1];
  assign dual_phase_o = state_ff.dual_phase;

endmodule : csar_strap_latch

// file: tb/csar_host_model.sv
// Purpose: host side of the byte register port, issues single reads and writes
// Assumes: ack answers one cycle after the strobe edge
// Notes: address and data lines show a changing pattern once released
`timescale 1ns/1ps

module csar_host_model (
  input wire logic clock_i,
  input wire csar_pkg::csar_reg_rsp_t reg_rsp_i,
  output csar_pkg::csar_reg_req_t reg_req_o,
  output logic timeout_o
);
  initial
  begin
    reg_req_o = '0;
    timeout_o = 1'b0;
  end

  // ==================================================================
  // one transfer: strobe for one cycle, then wait a bounded time for ack
  task automatic xfer(input logic is_rd, input logic [7:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    int n;
    begin
      n = 0;
      @(negedge clock_i);
      reg_req_o = '{is_rd, !is_rd, addr, wdata};
      @(negedge clock_i);
      reg_req_o = '{1'b0, 1'b0, ~addr, ~wdata};
      while (reg_rsp_i.ack !== 1'b1 && n < 4)
      begin
        @(negedge clock_i);
        n++;
      end
      if (reg_rsp_i.ack !== 1'b1)
        timeout_o = 1'b1;
      rdata = reg_rsp_i.rdata;
    end
  endtask : xfer
endmodule : csar_host_model

// file: tb/csar_status_bank_tb_top.sv
// Purpose: self-checking bench of the status and result bank
// Assumes: all inputs change at the falling clock edge
// Notes: lfsr stimulus with corner values mixed in
`timescale 1ns/1ps
`include "csar_cfg.svh"

module csar_status_bank_tb_top;
  logic clock_i;
  logic arst_n_i;
  csar_pkg::csar_reg_req_t req;
  csar_pkg::csar_reg_rsp_t rsp;
  csar_pkg::csar_status_t st;
  csar_pkg::csar_sample_t bs, ss, cs;
  logic soft_rst, chg_en, cv, term, tmr, therm, fsw, slow, dual, timeout;
  logic [2:0] strap;
  logic [15:0] short_mv, min_mv, bo, so, co, last_b, last_s, last_c, v;
  logic [31:0] seed = 32'h0000_764a;
  logic [7:0] d;
  logic [15:0] flags;
  int n_errors = 0;
  int checks = 0;
  logic [15:0] corner [6] = '{16'h7fff, 16'h8000, 16'h1fff, 16'h2000, 16'hffff, 16'h0001};

  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  csar_status_bank dut_u (.clock_i(clock_i), .arst_n_i(arst_n_i), .reg_req_i(req),
    .reg_rsp_o(rsp), .soft_reset_i(soft_rst), .charge_enable_i(chg_en), .cv_mode_i(cv),
    .term_done_i(term), .timer_expire_i(tmr), .thermal_regulation_i(therm), .strap_i(strap),
    .batt_short_mv_i(short_mv), .sys_min_mv_i(min_mv), .batt_sample_i(bs),
    .system_power_monitor_i(ss), .cmp_sample_i(cs), .status_o(st), .battery_voltage_o(bo),
    .system_power_result_o(so), .comparator_input_result_o(co), .fsw_800k_o(fsw),
    .slow_comp_o(slow), .dual_phase_o(dual));

  csar_host_model host_u (.clock_i(clock_i), .reg_rsp_i(rsp), .reg_req_o(req),
    .timeout_o(timeout));

  assign flags = {14'h0000, st.safety_timer_expired, st.thermal_regulation_active};

  // ==================================================================
  // expectations
  function automatic logic [15:0] eb(logic [15:0] x);
    return x[15] ? 16'h0000 : x;
  endfunction : eb

  function automatic logic [15:0] es(logic [15:0] x);
    return (x > 16'h1fff) ? 16'h1fff : x;
  endfunction : es

  function automatic logic [2:0] eph(logic e, logic t, logic c, logic [15:0] b, logic [15:0] s,
                                     logic [15:0] m);
    if (!e) return 3'h0;
    if (t) return 3'h7;
    if (b < s) return 3'h1;
    if (b < m) return 3'h2;
    return c ? 3'h4 : 3'h3;
  endfunction : eph

  // ==================================================================
  // helpers
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0040_0007 : 32'h0000_0000);
    return seed[15:0];
  endfunction : rnd

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    host_u.xfer(1'b1, a, 8'h00, r);
    chk_reg(r, exp);
  endtask : rd_chk

  task automatic rd_word(input logic [7:0] a, input logic [15:0] exp);
    rd_chk(a, exp[7:0]);
    rd_chk(a + 8'h01, exp[15:8]);
  endtask : rd_word

  task automatic do_reset(input logic [2:0] c);
    @(negedge clock_i);
    arst_n_i = 1'b0;
    strap = c;
    repeat (16) @(negedge clock_i);
    arst_n_i = 1'b1;
    repeat (2) @(negedge clock_i);
  endtask : do_reset

  task automatic put(input logic [15:0] b, input logic [15:0] s, input logic [15:0] c);
    @(negedge clock_i);
    bs = '{1'b1, b};
    ss = '{1'b1, s};
    cs = '{1'b1, c};
    @(negedge clock_i);
    bs = '{1'b0, ~b};
    ss = '{1'b0, ~s};
    cs = '{1'b0, ~c};
    last_b = eb(b);
    last_s = es(s);
    last_c = es(c);
    chk_val(bo, last_b);
    chk_val(so, last_s);
    chk_val(co, last_c);
  endtask : put

  task automatic final_report();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  always @(posedge timeout)
  begin
    n_errors++;
    final_report();
  end

  // ==================================================================
  // main sequence
  initial
  begin
    arst_n_i = 1'b0;
    {soft_rst, chg_en, cv, term, tmr, therm} = '0;
    strap = 3'h0;
    short_mv = 16'h0000;
    min_mv = 16'h0000;
    bs = '0;
    ss = '0;
    cs = '0;
    for (int c = 0; c < 8; c++)
    begin
      do_reset(3'(c));
      chk_reg(st, {5'h00, 3'(c)});
      chk_val({13'h0000, fsw, slow, dual}, {13'h0000, c[0], c[1], !c[2]});
      rd_chk(`CSAR_OFS_STATUS, {5'h00, 3'(c)});
    end
    foreach (corner[i]) rd_word(8'h1a + 8'(2 * (i % 3)), 16'h0000);
    rd_chk(8'h18, `CSAR_UNMAPPED_RD);
    rd_chk(8'h20, `CSAR_UNMAPPED_RD);
    $display("test reset_and_strap done");

    for (int i = 0; i < 14; i++)
    begin
      if (i < 6)
        v = corner[i];
      else
        v = rnd();
      put(v, ~v, {v[7:0], v[15:8]});
      rd_word(`CSAR_OFS_BATT_LO, last_b);
      rd_word(`CSAR_OFS_SYS_LO, last_s);
      rd_word(`CSAR_OFS_CMP_LO, last_c);
    end
    $display("test results done");

    put(16'h3000, 16'h0123, 16'h0456);
    for (int k = 0; k < 16; k++)
    begin
      @(negedge clock_i);
      chg_en = (k != 0);
      term = (k == 1);
      cv = k[0];
      short_mv = k[1] ? 16'h3001 : 16'h2fff;
      min_mv = k[2] ? 16'h3001 : 16'h3000;
      @(negedge clock_i);
      d = {eph(chg_en, term, cv, 16'h3000, short_mv, min_mv), 5'h07};
      chk_reg(st, d);
      rd_chk(`CSAR_OFS_STATUS, d);
    end
    $display("test phase done");

    @(negedge clock_i);
    tmr = 1'b1;
    therm = 1'b1;
    @(negedge clock_i);
    tmr = 1'b0;
    repeat (4) @(negedge clock_i);
    chk_val(flags, 16'h0003);
    soft_rst = 1'b1;
    @(negedge clock_i);
    soft_rst = 1'b0;
    chk_val(flags, 16'h0000);
    chk_val(so, 16'h0000);
    chk_val(bo, last_b);
    chk_val(co, last_c);
    @(negedge clock_i);
    chk_val(flags, 16'h0001);
    tmr = 1'b1;
    soft_rst = 1'b1;
    therm = 1'b0;
    @(negedge clock_i);
    {tmr, soft_rst} = 2'b00;
    chk_val(flags, 16'h0002);
    rd_word(`CSAR_OFS_SYS_LO, 16'h0000);
    $display("test timer_thermal done");

    for (int a = 8'h19; a < 8'h20; a++)
    begin
      v = rnd();
      host_u.xfer(1'b0, 8'(a), v[7:0], d);
    end
    d = {eph(chg_en, term, cv, 16'h3000, short_mv, min_mv), 5'h17};
    rd_chk(`CSAR_OFS_STATUS, d);
    rd_word(`CSAR_OFS_BATT_LO, last_b);
    rd_word(`CSAR_OFS_SYS_LO, 16'h0000);
    rd_word(`CSAR_OFS_CMP_LO, last_c);
    $display("test writes done");
    final_report();
  end
endmodule : csar_status_bank_tb_top
